// *** core/annpr_consts.svh ***
/*
 * Offsets, field positions and reset values of the next-page register pair.
 * Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
 */
`ifndef ANNPR_CONSTS_SVH
`define ANNPR_CONSTS_SVH

// Register indices; byte address is four times the index
`define ANNPR_IDX_TX 4'h7
`define ANNPR_IDX_RX 4'h8

// Field positions inside each 16-bit page
`define ANNPR_B_MORE 15
`define ANNPR_B_ACK 14
`define ANNPR_B_MSG 13
`define ANNPR_B_COMPLY 12
`define ANNPR_B_TOG 11
`define ANNPR_CODE_HI 10

// Reset values: more pages, message page, null message code
`define ANNPR_TX_RST 16'hA008
`define ANNPR_RX_RST 16'h0000
// One bit of the transmit reset word, and its code field alone
`define ANNPR_TX_RST_BIT(n) 1'(`ANNPR_TX_RST >> (n))
`define ANNPR_TX_RST_CODE 11'h008

// AXI responses
`define ANNPR_RESP_OKAY 2'h0
`define ANNPR_RESP_SLVERR 2'h2

`endif

// *** core/annpr_pkg.sv ***
/*
 * Types shared by the next-page register pair.
 * Assumes the constants header is included by the modules that need it.
 */
package annpr_pkg;

  // One next-page link code word
  typedef struct packed {
    logic more_pages_flag;
    logic ack_flag;
    logic message_page_flag;
    logic comply_flag;
    logic toggle_state;
    logic [10:0] code;
  } annpr_page_t;

  // Register selected by an address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_TX,
    SEL_RX
  } annpr_sel_t;

endpackage : annpr_pkg

// *** core/annpr_regs.sv ***
/*
 * Next-page transmit and receive registers behind an AXI4-Lite slave.
 * Assumes the arbitration logic outside strobes received pages,
 * acknowledge completion, page exchange and restart, one cycle each.
 */
// Chosen here: register access over AXI4-Lite.
// Summary of operation
// RULE1: Transmit bit 15 read/write, reset 1; requests another next page.
// RULE2: Transmit bit 14 read-only, reset 0, set after three acknowledged bursts.
// RULE3: Transmit bit 12 read/write, reset 0; local device will comply.
// RULE4: Transmit bit 11 read-only, always inverse of last exchanged toggle; here AN_RESTART clears it to 0, also in a cycle with TX_PAGE_SENT.
// RULE5: Transmit bits 10:0 writable code; bit 13 read/write reset 1 selects message.
// RULE6: Transmit code resets to the null message code.
// RULE7: Transmit register contents are sent as the next-page code word.
// RULE8: Receive bits 15, 14, 13 read-only, reset 0, partner flags.
// RULE9: Receive bit 12 read-only, reset 0, partner can comply.
// RULE10: Receive bit 11 and bits 10:0 show partner toggle and code.
// RULE11: Receive fields all update together when a partner page is accepted.
`timescale 1ns/1ps
`include "annpr_consts.svh"

module annpr_regs #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Arbitration side
  input wire logic RX_PAGE_VALID,
  input wire logic [15:0] RX_PAGE,
  input wire logic TX_ACK_SET,
  input wire logic TX_PAGE_SENT,
  input wire logic AN_RESTART,
  output logic [15:0] TX_PAGE
);

  logic rst_s1_q;
  logic rst_n_q;
  annpr_pkg::annpr_page_t tx_word;
  logic more_q;
  logic msg_q;
  logic comply_q;
  logic [10:0] code_q;
  logic ack_q;
  logic tog_q;
  annpr_pkg::annpr_page_t rx_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_fire;
  logic w_fire;
  logic wr_do;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  annpr_pkg::annpr_sel_t wr_sel;
  annpr_pkg::annpr_sel_t rd_sel;
  logic rd_do;

  // Address decode shared by read and write paths
  function automatic annpr_pkg::annpr_sel_t annpr_decode(input logic [ADDR_W-1:0] a);
    annpr_pkg::annpr_sel_t s;
    s = annpr_pkg::SEL_NONE;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:2] == (ADDR_W-2)'(`ANNPR_IDX_TX)) begin
      s = annpr_pkg::SEL_TX;
    end else if (a[1:0] == 2'h0 && a[ADDR_W-1:2] == (ADDR_W-2)'(`ANNPR_IDX_RX)) begin
      s = annpr_pkg::SEL_RX;
    end
    return s;
  endfunction : annpr_decode

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // Write channel handshakes; address and data in either order
  assign AWREADY = !aw_have_q && !bvalid_q;
  assign WREADY = !w_have_q && !bvalid_q;
  assign aw_fire = AWVALID && AWREADY;
  assign w_fire = WVALID && WREADY;
  assign wr_do = (aw_have_q || aw_fire) && (w_have_q || w_fire) && !bvalid_q;
  assign wr_addr = aw_have_q ? aw_addr_q : AWADDR;
  assign wr_data = w_have_q ? w_data_q : WDATA;
  assign wr_strb = w_have_q ? w_strb_q : WSTRB;
  assign wr_sel = annpr_decode(wr_addr);

  // Hold whichever half of a write arrives first
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (aw_fire && !wr_do) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
      if (w_fire && !wr_do) begin
        w_have_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ANNPR_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_sel == annpr_pkg::SEL_NONE) ? `ANNPR_RESP_SLVERR : `ANNPR_RESP_OKAY;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // Writable transmit fields; lane 0 low code, lane 1 flags and high code
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      more_q <= `ANNPR_TX_RST_BIT(`ANNPR_B_MORE); // [RULE1]
      msg_q <= `ANNPR_TX_RST_BIT(`ANNPR_B_MSG); // [RULE5]
      comply_q <= `ANNPR_TX_RST_BIT(`ANNPR_B_COMPLY); // [RULE3]
      code_q <= `ANNPR_TX_RST_CODE; // [RULE6]
    end else if (wr_do && wr_sel == annpr_pkg::SEL_TX) begin
      if (wr_strb[0]) begin
        code_q[7:0] <= wr_data[7:0]; // [RULE5]
      end
      if (wr_strb[1]) begin
        more_q <= wr_data[`ANNPR_B_MORE]; // [RULE1]
        msg_q <= wr_data[`ANNPR_B_MSG]; // [RULE5]
        comply_q <= wr_data[`ANNPR_B_COMPLY]; // [RULE3]
        code_q[`ANNPR_CODE_HI:8] <= wr_data[`ANNPR_CODE_HI:8]; // [RULE5]
      end
    end
  end

  // Acknowledge; a set in the restart cycle wins
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else if (TX_ACK_SET) begin
      ack_q <= 1'b1; // [RULE2]
    end else if (AN_RESTART) begin
      ack_q <= 1'b0; // [RULE2]
    end
  end

  // Toggle flips after each exchanged page, restart returns it to 0
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tog_q <= 1'b0;
    end else if (AN_RESTART) begin
      tog_q <= 1'b0;
    end else if (TX_PAGE_SENT) begin
      tog_q <= !tog_q; // [RULE4]
    end
  end

  // Transmit word gathered from its field flops, one driver each
  assign tx_word = {more_q, ack_q, msg_q, comply_q, tog_q, code_q};

  // Page offered to the partner is the transmit register itself
  assign TX_PAGE = tx_word; // [RULE7]

  // Partner page captured whole in one edge
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_q <= `ANNPR_RX_RST; // [RULE8] [RULE9]
    end else if (RX_PAGE_VALID) begin
      rx_q <= RX_PAGE; // [RULE8] [RULE9] [RULE10] [RULE11]
    end
  end

  // Read channel; one read outstanding, data one cycle after address
  assign ARREADY = !rvalid_q;
  assign rd_do = ARVALID && ARREADY;
  assign rd_sel = annpr_decode(ARADDR);
  always_ff @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ANNPR_RESP_OKAY;
    end else if (rd_do) begin
      rvalid_q <= 1'b1;
      rresp_q <= `ANNPR_RESP_OKAY;
      case (rd_sel)
        annpr_pkg::SEL_TX: rdata_q <= {16'h0000, tx_word};
        annpr_pkg::SEL_RX: rdata_q <= {16'h0000, rx_q}; // [RULE10]
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `ANNPR_RESP_SLVERR;
        end
      endcase
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // Checks on register behaviour
  property p_more_write;
    @(posedge MCLK) disable iff (!rst_n_q)
    wr_do && wr_sel == annpr_pkg::SEL_TX && wr_strb[1]
      |=> more_q == $past(wr_data[`ANNPR_B_MORE]);
  endproperty
  a_more_write: assert property (p_more_write) else $error("more pages not written"); // [RULE1]

  property p_ack_set;
    @(posedge MCLK) disable iff (!rst_n_q)
    TX_ACK_SET |=> ack_q ##1 (ack_q || $past(AN_RESTART));
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("acknowledge not set"); // [RULE2]

  property p_ack_clr;
    @(posedge MCLK) disable iff (!rst_n_q)
    AN_RESTART && !TX_ACK_SET |=> !ack_q;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("acknowledge not cleared"); // [RULE2]

  property p_comply_keep;
    @(posedge MCLK) disable iff (!rst_n_q)
    !(wr_do && wr_sel == annpr_pkg::SEL_TX && wr_strb[1]) |=> $stable(comply_q);
  endproperty
  a_comply_keep: assert property (p_comply_keep) else $error("comply changed unasked"); // [RULE3]

  property p_toggle;
    @(posedge MCLK) disable iff (!rst_n_q)
    TX_PAGE_SENT && !AN_RESTART |=> TX_PAGE[`ANNPR_B_TOG] != $past(TX_PAGE[`ANNPR_B_TOG]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not invert"); // [RULE4]

  property p_code_write;
    @(posedge MCLK) disable iff (!rst_n_q)
    wr_do && wr_sel == annpr_pkg::SEL_TX && wr_strb[0] |=> TX_PAGE[7:0] == $past(wr_data[7:0]);
  endproperty
  a_code_write: assert property (p_code_write) else $error("code not sent as written"); // [RULE5] [RULE7]

  property p_rx_capture;
    @(posedge MCLK) disable iff (!rst_n_q)
    RX_PAGE_VALID |=> rx_q == $past(RX_PAGE) ##1 ($past(RX_PAGE_VALID) || $stable(rx_q));
  endproperty
  a_rx_capture: assert property (p_rx_capture) else $error("partner page not held"); // [RULE11]

  property p_rx_read;
    @(posedge MCLK) disable iff (!rst_n_q)
    rd_do && rd_sel == annpr_pkg::SEL_RX && !RX_PAGE_VALID |=> RDATA == {16'h0000, rx_q};
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("partner page read wrong"); // [RULE8] [RULE9] [RULE10]

  property p_unmapped;
    @(posedge MCLK) disable iff (!rst_n_q)
    wr_do && wr_sel == annpr_pkg::SEL_NONE |=> BVALID && BRESP == `ANNPR_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");

  property p_rhold;
    @(posedge MCLK) disable iff (!rst_n_q)
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");

  // Main scenarios
  c_tx_write: cover property (@(posedge MCLK) disable iff (!rst_n_q)
    wr_do && wr_sel == annpr_pkg::SEL_TX);
  c_rx_page: cover property (@(posedge MCLK) disable iff (!rst_n_q)
    RX_PAGE_VALID ##1 rd_do && rd_sel == annpr_pkg::SEL_RX);
  c_ack_restart: cover property (@(posedge MCLK) disable iff (!rst_n_q)
    TX_ACK_SET && AN_RESTART);
  c_toggle_twice: cover property (@(posedge MCLK) disable iff (!rst_n_q)
    TX_PAGE_SENT ##[1:20] TX_PAGE_SENT);

endmodule : annpr_regs

// *** sim/annpr_partner.sv ***
/* Link-partner model driving received pages and exchange strobes.
   Assumes one clock shared with the register block. */
`timescale 1ns/1ps
module annpr_partner (
  // Clock
  input wire logic clk,
  // Received page
  output logic rx_valid,
  output logic [15:0] rx_page,
  // Exchange strobes
  output logic ack,
  output logic sent,
  output logic restart
);
  // Idle values
  initial begin
    rx_valid = 1'b0;
    rx_page = 16'h5A5A;
    {restart, sent, ack} = 3'h0;
  end

  // Whole page in one cycle, then the bus shows the inverse
  task automatic send_page(input annpr_pkg::annpr_page_t p);
    @(posedge clk);
    rx_page <= p;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_page <= ~p;
  endtask : send_page

  // One-cycle strobes: bit 0 ack, bit 1 exchange, bit 2 restart
  task automatic pulse(input logic [2:0] s);
    @(posedge clk);
    {restart, sent, ack} <= s;
    @(posedge clk);
    {restart, sent, ack} <= 3'h0;
  endtask : pulse
endmodule : annpr_partner

// *** sim/tb.sv ***
/* Self-checking bench for the next-page register pair.
   Assumes the design and partner model are compiled first. */
`timescale 1ns/1ps
`include "annpr_consts.svh"
module tb;
  // Bus, link and bench state
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic [5:0] AWADDR = 6'h0;
  logic [5:0] ARADDR = 6'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, r;
  logic [31:0] RDATA, d, w;
  logic [15:0] RX_PAGE, TX_PAGE, exp_tx;
  logic RX_PAGE_VALID, TX_ACK_SET, TX_PAGE_SENT, AN_RESTART;
  logic [2:0] s3;
  int errors = 0, check_count = 0, cyc = 0;
  localparam logic [5:0] A_TX = {`ANNPR_IDX_TX, 2'b00};
  localparam logic [5:0] A_RX = {`ANNPR_IDX_RX, 2'b00};

  always #5 MCLK = ~MCLK;

  annpr_regs i_annpr_regs (.MCLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .RX_PAGE_VALID, .RX_PAGE, .TX_ACK_SET, .TX_PAGE_SENT,
    .AN_RESTART, .TX_PAGE);

  annpr_partner i_annpr_partner (.clk(MCLK), .rx_valid(RX_PAGE_VALID), .rx_page(RX_PAGE),
    .ack(TX_ACK_SET), .sent(TX_PAGE_SENT), .restart(AN_RESTART));

  // Expected transmit word after a write; read-only bits kept
  function automatic logic [15:0] wr_exp(input logic [15:0] c, wd, input logic [3:0] st);
    logic [15:0] m;
    m = {{8{st[1]}}, {8{st[0]}}} & 16'hB7FF;
    return (c & ~m) | (wd & m);
  endfunction : wr_exp

  // Expected transmit word after strobes; set beats restart
  function automatic logic [15:0] sb_exp(input logic [15:0] c, input logic [2:0] s);
    logic [15:0] e;
    e = c;
    e[14] = s[0] | (c[14] & ~s[2]);
    e[11] = ~s[2] & (c[11] ^ s[1]);
    return e;
  endfunction : sb_exp

  // Compare response and data
  task automatic chk(input logic [33:0] g, e, input string m);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // Bus write; response left in r
  task automatic axw(input logic [5:0] a, input logic [31:0] dat, input logic [3:0] st);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= dat;
    WSTRB <= st;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask : axw

  // Bus read; data in d, response in r
  task automatic axr(input logic [5:0] a);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask : axr

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Hang guard
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h8560));
    repeat (20) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (4) @(posedge MCLK);
    exp_tx = `ANNPR_TX_RST;
    axr(A_TX);
    chk({r, d}, {18'h0, exp_tx}, "tx reset");
    chk({18'h0, TX_PAGE}, {18'h0, exp_tx}, "tx page reset");
    axr(A_RX);
    chk({r, d}, 34'h0, "rx reset");
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      axw(A_TX, w, (i == 0) ? 4'h3 : 4'($urandom));
      exp_tx = wr_exp(exp_tx, w[15:0], WSTRB);
      axr(A_TX);
      chk({r, d}, {18'h0, exp_tx}, "tx write");
      chk({18'h0, TX_PAGE}, {18'h0, exp_tx}, "tx page");
    end
    $display("test writes done");
    for (int i = 0; i < 14; i++) begin
      s3 = (i < 8) ? 3'(i) : 3'($urandom);
      i_annpr_partner.pulse(s3);
      exp_tx = sb_exp(exp_tx, s3);
      axr(A_TX);
      chk({r, d}, {18'h0, exp_tx}, "tx status");
      chk({18'h0, TX_PAGE}, {18'h0, exp_tx}, "tx page status");
    end
    $display("test strobes done");
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? 32'hFFFF : $urandom;
      i_annpr_partner.send_page(w[15:0]);
      axw(A_RX, ~w, 4'hF);
      chk({r, 32'h0}, 34'h0, "rx write resp");
      axr(A_RX);
      chk({r, d}, {18'h0, w[15:0]}, "rx page");
    end
    $display("test receive done");
    axw(6'h3C, 32'hFFFF, 4'hF);
    chk({r, 32'h0}, {2'h2, 32'h0}, "unmapped write");
    axr(6'h3C);
    chk({r, d}, {2'h2, 32'h0}, "unmapped read");
    axr(A_TX);
    chk({r, d}, {18'h0, exp_tx}, "tx after unmapped");
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : tb
